//--- e1ai_alarm_irq.sv
// e1 receive framer alarm status, change indications and interrupt gating
`timescale 1ns/1ps
`default_nettype none
module e1ai_alarm_irq (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // classic wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [e1ai_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [e1ai_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [e1ai_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  // live state from the receive frame processor
  input  wire logic                        interwork_active,
  input  wire logic                        frame_unsynced,
  input  wire logic                        sig_mf_unsynced,
  input  wire logic                        crc_mf_unsynced,
  input  wire logic                        offline_framer_unsynced,
  input  wire logic                        alarm_and_block_err_10ms,
  input  wire logic                        sustained_block_err,
  input  wire logic                        link_id_received,
  input  wire logic                        remote_alarm_state,
  input  wire logic                        mf_remote_alarm_state,
  input  wire logic                        ais_detect_state,
  input  wire logic                        red_alarm_state,
  input  wire logic                        ais_persist_state,
  // one-cycle event pulses from the receive frame processor
  input  wire logic                        align_move,
  input  wire logic                        frame_pattern_err,
  input  wire logic                        sig_mf_pattern_err,
  input  wire logic                        crc_mf_pattern_err,
  input  wire logic                        far_block_err,
  input  wire logic                        crc_mismatch,
  // shared interrupt
  output logic                             irq_n
);

  localparam int unsigned RW = e1ai_pkg::REG_W;

  function automatic logic hit(input logic [e1ai_pkg::IDX_W-1:0] idx,
                               input logic [e1ai_pkg::IDX_W-1:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  logic [RW-1:0] frmEn_q;
  logic [RW-1:0] mntEn_q;
  logic [RW-1:0] frmInd_q;
  logic [RW-1:0] frmInd_d;
  logic [RW-1:0] mntInd_q;
  logic [RW-1:0] mntInd_d;
  logic [RW-1:0] frmLive;
  logic [RW-1:0] mntLive;
  logic [RW-1:0] frmLive_q;
  logic [RW-1:0] mntLive_q;
  logic [RW-1:0] frmSet;
  logic [RW-1:0] mntSet;
  logic [RW-1:0] rdMux;
  logic          primed_q;
  logic          ack_q;
  logic          irqN_q;
  logic [e1ai_pkg::DAT_W-1:0] dat_q;
  logic [e1ai_pkg::IDX_W-1:0] idx;
  logic          access;
  logic          wrLane0;
  logic          rdFrmInd;
  logic          rdMntInd;

  assign idx      = wb_adr_i[e1ai_pkg::ADR_W-1:2];
  assign access   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wrLane0  = access & wb_we_i & wb_sel_i[0];
  assign rdFrmInd = access & ~wb_we_i & hit(idx, e1ai_pkg::IDX_FRM_IND);
  assign rdMntInd = access & ~wb_we_i & hit(idx, e1ai_pkg::IDX_MNT_IND);

  // live status bits as software sees them
  assign frmLive = {interwork_active,
                    frame_unsynced,
                    sig_mf_unsynced,
                    crc_mf_unsynced,
                    offline_framer_unsynced,
                    alarm_and_block_err_10ms,
                    sustained_block_err,
                    link_id_received};
  assign mntLive = {remote_alarm_state, mf_remote_alarm_state, ais_detect_state, 1'b0,
                    red_alarm_state, ais_persist_state, 2'b00};

  // last seen live state; the first cycle after reset only loads it, so a
  // status that is already asserted at reset does not post a false change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frmLive_q <= e1ai_pkg::RST_ZERO;
      mntLive_q <= e1ai_pkg::RST_ZERO;
      primed_q  <= 1'b0;
    end else begin
      frmLive_q <= frmLive;
      mntLive_q <= mntLive;
      primed_q  <= 1'b1;
    end
  end

  // set sources for both indication registers
  generate
    for (genvar i = 0; i < e1ai_pkg::FRM_LIVE_N; i++) begin : g_frm_chg
      assign frmSet[e1ai_pkg::FRM_LIVE_LO+i] = primed_q &
        (frmLive[e1ai_pkg::FRM_LIVE_LO+i] ^ frmLive_q[e1ai_pkg::FRM_LIVE_LO+i]);
    end
  endgenerate
  assign frmSet[e1ai_pkg::FRM_LIVE_LO-1:0] = {align_move,
                                              frame_pattern_err,
                                              sig_mf_pattern_err,
                                              crc_mf_pattern_err};

  always_comb begin
    mntSet = {RW{primed_q}} & (mntLive ^ mntLive_q) & e1ai_pkg::MNT_LIVE_MASK;
    mntSet[e1ai_pkg::MNT_FEBE] = far_block_err;
    mntSet[e1ai_pkg::MNT_CRC]  = crc_mismatch;
  end

  // clear on read, but an event in the reading cycle survives the clear
  always_comb begin
    frmInd_d = (frmInd_q & ~{RW{rdFrmInd}}) | frmSet;
    mntInd_d = (mntInd_q & ~{RW{rdMntInd}}) | mntSet;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frmInd_q <= e1ai_pkg::RST_ZERO;
      mntInd_q <= e1ai_pkg::RST_ZERO;
    end else begin
      frmInd_q <= frmInd_d;
      mntInd_q <= mntInd_d;
    end
  end

  // enable registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frmEn_q <= e1ai_pkg::RST_FRM_EN;
      mntEn_q <= e1ai_pkg::RST_MNT_EN;
    end else begin
      if (wrLane0 && hit(idx, e1ai_pkg::IDX_FRM_EN)) begin
        frmEn_q <= wb_dat_i[RW-1:0];
      end
      if (wrLane0 && hit(idx, e1ai_pkg::IDX_MNT_EN)) begin
        mntEn_q <= wb_dat_i[RW-1:0] & (e1ai_pkg::MNT_LIVE_MASK |
                   RW'(1 << e1ai_pkg::MNT_FEBE) | RW'(1 << e1ai_pkg::MNT_CRC));
      end
    end
  end

  // read data mux; unmapped words read zero and still get an ack
  always_comb begin
    rdMux = e1ai_pkg::RST_ZERO;
    if (hit(idx, e1ai_pkg::IDX_FRM_EN)) begin
      rdMux = frmEn_q;
    end else if (hit(idx, e1ai_pkg::IDX_MNT_EN)) begin
      rdMux = mntEn_q;
    end else if (hit(idx, e1ai_pkg::IDX_FRM_IND)) begin
      rdMux = frmInd_q;
    end else if (hit(idx, e1ai_pkg::IDX_MNT_IND)) begin
      rdMux = mntInd_q;
    end else if (hit(idx, e1ai_pkg::IDX_FRM_STAT)) begin
      rdMux = frmLive_q;
    end else if (hit(idx, e1ai_pkg::IDX_MNT_STAT)) begin
      rdMux = mntLive_q;
    end
  end

  // one wait state: ack and data both come from flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= e1ai_pkg::DAT_ZERO;
    end else begin
      ack_q <= access;
      if (access && !wb_we_i) begin
        dat_q <= {{(e1ai_pkg::DAT_W-RW){1'b0}}, rdMux};
      end
    end
  end

  // interrupt gating; a flag set this cycle shows on irq_n one edge later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqN_q <= 1'b1;
    end else begin
      irqN_q <= ~(|(frmInd_q & frmEn_q) | |(mntInd_q & mntEn_q));
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_n    = irqN_q;

endmodule
`default_nettype wire

//--- e1ai_host_model.sv
// classic wishbone host that services the block's registers
`timescale 1ns/1ps
`default_nettype none
module e1ai_host_model (
  // clock
  input  wire logic                       sys_clk,
  // wishbone master side
  output logic                            wb_cyc_o,
  output logic                            wb_stb_o,
  output logic                            wb_we_o,
  output logic [e1ai_pkg::ADR_W-1:0]      wb_adr_o,
  output logic [3:0]                      wb_sel_o,
  output logic [e1ai_pkg::DAT_W-1:0]      wb_dat_o,
  input  wire logic [e1ai_pkg::DAT_W-1:0] wb_dat_i,
  input  wire logic                       wb_ack_i
);
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_dat_o} = '0;
    wb_sel_o = 4'h1;
  end
  // the bench watchdog bounds the wait for ack
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_sel_o <= 4'h1;
    wb_adr_o <= {idx, 2'b00};
    wb_dat_o <= {24'h000000, d};
    do @(posedge sys_clk); while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- e1ai_monitor.sv
// port checker for the alarm interrupt block
`timescale 1ns/1ps
`default_nettype none
module e1ai_monitor (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // register bus
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [e1ai_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [e1ai_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic                       wb_ack_o,
  // causes and interrupt
  input wire logic                       frame_unsynced,
  input wire logic                       remote_alarm_state,
  input wire logic                       align_move,
  input wire logic                       far_block_err,
  input wire logic                       crc_mismatch,
  input wire logic                       irq_n
);
  logic [7:0] fEnQ;
  logic [7:0] mEnQ;
  // shadow enables lag the design by one edge, so causes stay clear of writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fEnQ <= e1ai_pkg::RST_FRM_EN;
      mEnQ <= e1ai_pkg::RST_MNT_EN;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i[11:2] == e1ai_pkg::IDX_FRM_EN) fEnQ <= wb_dat_i[7:0];
      if (wb_adr_i[11:2] == e1ai_pkg::IDX_MNT_EN) mEnQ <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_oof; $changed(frame_unsynced) && $past(rst_n) && fEnQ[6] |-> ##3 !irq_n; endproperty
  a_oof: assert property (p_oof) else $error("frame sync irq");
  property p_move; align_move && fEnQ[3] |-> ##2 !irq_n; endproperty
  a_move: assert property (p_move) else $error("align irq");
  property p_febe; far_block_err && mEnQ[1] |-> ##2 !irq_n; endproperty
  a_febe: assert property (p_febe) else $error("block err irq");
  property p_crc; crc_mismatch && mEnQ[0] |-> ##2 !irq_n; endproperty
  a_crc: assert property (p_crc) else $error("crc irq");
  property p_ra; $changed(remote_alarm_state) && $past(rst_n) && mEnQ[7] |-> ##3 !irq_n; endproperty
  a_ra: assert property (p_ra) else $error("alarm irq");
  property p_rise; $rose(irq_n) |-> $past(wb_ack_o); endproperty
  a_rise: assert property (p_rise) else $error("irq released");
  property p_off; (fEnQ == 8'h00 && mEnQ == 8'h00) [*3] |-> irq_n; endproperty
  a_off: assert property (p_off) else $error("masked irq");
endmodule
bind e1ai_alarm_irq e1ai_monitor u_mon (.*);
`default_nettype wire

//--- e1ai_pkg.sv
// constants for the e1 framer alarm and interrupt block
package e1ai_pkg;
  // wishbone geometry
  localparam int unsigned ADR_W = 12;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 10;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FRM_EN   = 10'h032;
  localparam logic [IDX_W-1:0] IDX_MNT_EN   = 10'h033;
  localparam logic [IDX_W-1:0] IDX_FRM_IND  = 10'h034;
  localparam logic [IDX_W-1:0] IDX_MNT_IND  = 10'h035;
  localparam logic [IDX_W-1:0] IDX_FRM_STAT = 10'h036;
  localparam logic [IDX_W-1:0] IDX_MNT_STAT = 10'h037;
  // reset values
  localparam logic [REG_W-1:0] RST_FRM_EN = 8'h02;
  localparam logic [REG_W-1:0] RST_MNT_EN = 8'h00;
  localparam logic [REG_W-1:0] RST_ZERO   = 8'h00;
  // maintenance register: live bits 7,6,5,3,2; bit 4 reserved
  localparam logic [REG_W-1:0] MNT_LIVE_MASK = 8'hEC;
  // framing register: live-change bits 7..4, event bits 3..0
  localparam int unsigned FRM_LIVE_LO = 4;
  localparam int unsigned FRM_LIVE_N  = 4;
  localparam int unsigned MNT_FEBE    = 1;
  localparam int unsigned MNT_CRC     = 0;
  localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;
endpackage

//--- e1ai_testbench.sv
// self-checking bench for the alarm interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, cyc, stb, we, ack, irq_n;
  logic [e1ai_pkg::ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [e1ai_pkg::DAT_W-1:0] datI, datO;
  logic [7:0] fLv = 8'h00, mLv = 8'h00, q;
  logic [3:0] fEv = 4'h0;
  logic [1:0] mEv = 2'h0;
  int fail_count = 0, cmp_count = 0;
  e1ai_host_model h (.sys_clk(sys_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(datI), .wb_dat_i(datO), .wb_ack_i(ack));
  e1ai_alarm_irq DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .interwork_active(fLv[7]), .frame_unsynced(fLv[6]),
    .sig_mf_unsynced(fLv[5]), .crc_mf_unsynced(fLv[4]), .offline_framer_unsynced(fLv[3]),
    .alarm_and_block_err_10ms(fLv[2]), .sustained_block_err(fLv[1]),
    .link_id_received(fLv[0]), .remote_alarm_state(mLv[7]), .mf_remote_alarm_state(mLv[6]),
    .ais_detect_state(mLv[5]), .red_alarm_state(mLv[3]), .ais_persist_state(mLv[2]),
    .align_move(fEv[3]), .frame_pattern_err(fEv[2]), .sig_mf_pattern_err(fEv[1]),
    .crc_mf_pattern_err(fEv[0]), .far_block_err(mEv[1]), .crc_mismatch(mEv[0]),
    .irq_n(irq_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    h.xfer(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask
  // toggles the live bit or pulses the event behind flag b of register r
  task automatic cause(input int r, input int b);
    @(posedge sys_clk);
    if (r == 0 && b > 3) fLv[b] <= ~fLv[b];
    else if (r == 0) fEv[b] <= 1'b1;
    else if (b > 1) mLv[b] <= ~mLv[b];
    else mEv[b] <= 1'b1;
    @(posedge sys_clk);
    fEv <= 4'h0;
    mEv <= 2'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  task final_report;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #40000;
    fail_count++;
    final_report;
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({7'h00, irq_n}, 8'h01);
    rdc(10'h033, 8'h00);
    rdc(10'h035, 8'h00);
    h.xfer(1'b1, 10'h032, 8'h00, q);
    h.xfer(1'b1, 10'h040, 8'hFF, q);
    rdc(10'h040, 8'h00);
    for (int i = 0; i < 2; i++) begin
      fLv <= i ? 8'h5A : 8'hA5;
      mLv <= i ? 8'h00 : 8'hEC;
      h.xfer(1'b1, 10'h036, 8'h00, q);
      rdc(10'h036, i ? 8'h5A : 8'hA5);
      rdc(10'h037, i ? 8'h00 : 8'hEC);
    end
    rdc(10'h034, 8'hF0);
    rdc(10'h035, 8'hEC);
    for (int r = 0; r < 2; r++) begin
      for (int b = 0; b < 8; b++) begin
        if (r == 1 && b == 4) continue;
        h.xfer(1'b1, 10'(10'h032 + r), ~(8'h01 << b), q);
        h.xfer(1'b0, 10'(10'h034 + r), 8'h00, q);
        cause(r, b);
        chk({7'h00, irq_n}, 8'h01);
        h.xfer(1'b1, 10'(10'h032 + r), 8'h01 << b, q);
        h.xfer(1'b0, 10'(10'h034 + r), 8'h00, q);
        cause(r, b);
        chk({7'h00, irq_n}, 8'h00);
        rdc(10'(10'h034 + r), 8'h01 << b);
        rdc(10'(10'h034 + r), 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        h.xfer(1'b1, 10'(10'h032 + r), 8'h00, q);
      end
    end
    final_report;
  end
endmodule
`default_nettype wire
